// File: qe_counter_top.sv
// Four-channel incremental encoder counter with filters, latches, timer and flags.
`timescale 1ns/1ps
`default_nettype none
module qe_counter_top
  import qe_pkg::*;
#(
  parameter int          CHANNELS        = 4,
  parameter int unsigned TICK_CYCLES_PAR = TICK_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic [3:0]  enc_a_in,
  input  wire logic [3:0]  enc_b_in,
  input  wire logic [3:0]  enc_index_in,
  input  wire logic [3:0]  digital_input_in,
  input  wire logic [3:0]  board_id_in,
  output logic             irq_out
);

  if (CHANNELS != 4) begin : g_chk_ch
    $error("qe_counter_top serves exactly four channels");
  end
  if (TICK_CYCLES_PAR < 2 || TICK_CYCLES_PAR > 1600) begin : g_chk_tick
    $error("qe_counter_top TICK_CYCLES_PAR out of range");
  end

  // ***********************************************
  // State
  // ***********************************************
  logic [5:0]        samp_acc,  next_samp_acc;
  logic              sample_en, next_sample_en;
  logic [1:0]        samp_sel;
  logic [7:0]        timer_div;
  logic [2:0]        timer_base;
  logic [23:0]       tick_cnt,  next_tick_cnt;
  logic [7:0]        intv_cnt,  next_intv_cnt;
  logic              timer_pulse, next_timer_pulse;
  logic [31:0]       count     [4];
  logic [31:0]       next_count[4];
  logic [31:0]       latch     [4];
  logic [31:0]       next_latch[4];
  logic [31:0]       cmp       [4];
  logic [2:0]        cmode     [4];
  logic [3:0]        rvs;
  logic [2:0]        lsrc      [4];
  logic [31:0]       int_en;
  logic [31:0]       flags,     next_flags;
  logic [31:0]       next_rdata;
  logic              next_irq;
  logic [3:0]        board_id;
  logic [3:0]        a_f, b_f, x_f, d_f;
  logic [3:0]        a_p, b_p, x_p, d_p;
  logic [23:0]       tick_limit;

  // ***********************************************
  // Sampling clock enable and input filters
  // ***********************************************
  // A fractional accumulator gives an exact average of 8/4/2/1 MHz from 50 MHz;
  // the pulses jitter by one system cycle, far below one sampling period.
  always_comb begin
    logic [6:0] sum;
    sum            = {1'b0, samp_acc} + 7'((SAMPLE_MAX_MHZ >> samp_sel)); // RULE2 RULE22
    next_sample_en = 1'b0;
    next_samp_acc  = sum[5:0];
    if (sum >= 7'(SYS_CLK_MHZ)) begin
      next_sample_en = 1'b1;
      next_samp_acc  = 6'(sum - 7'(SYS_CLK_MHZ));
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      samp_acc  <= '0;
      sample_en <= 1'b0;
    end else begin
      samp_acc  <= next_samp_acc;
      sample_en <= next_sample_en;
    end
  end

  // Every encoder, index and digital line passes its own filter.
  for (genvar i = 0; i < 16; i++) begin : g_filt
    logic raw;
    logic filt;
    assign raw = (i < 4) ? enc_a_in[i % 4] : (i < 8) ? enc_b_in[i % 4] :
                 (i < 12) ? enc_index_in[i % 4] : digital_input_in[i % 4];
    qe_glitch_filter #(.DEPTH(FILTER_DEPTH)) u_filt (
      .clk_in       (clk_in),
      .rst_b_in     (rst_b_in),
      .sample_en_in (sample_en),
      .raw_in       (raw),
      .filt_out     (filt)
    );
    if (i < 4) begin : g_a
      assign a_f[i] = filt;
    end else if (i < 8) begin : g_b
      assign b_f[i-4] = filt;
    end else if (i < 12) begin : g_x
      assign x_f[i-8] = filt;
    end else begin : g_d
      assign d_f[i-12] = filt;
    end
  end

  // ***********************************************
  // Periodic timer
  // ***********************************************
  // Base tick is 20 us times a decade per time base step; five steps are legal.
  always_comb begin
    tick_limit = 24'(TICK_CYCLES_PAR - 1);
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < timer_base) begin
        tick_limit = 24'((tick_limit + 24'd1) * 24'd10 - 24'd1);
      end
    end
  end

  always_comb begin
    next_tick_cnt    = tick_cnt;
    next_intv_cnt    = intv_cnt;
    next_timer_pulse = 1'b0;
    if (timer_base > TB_LAST || timer_div == 8'h00) begin
      next_tick_cnt = '0;
      next_intv_cnt = '0;
    end else if (tick_cnt >= tick_limit) begin
      next_tick_cnt = '0;
      if (intv_cnt >= timer_div - 8'h01) begin
        next_intv_cnt    = '0;
        next_timer_pulse = 1'b1; // RULE18
      end else begin
        next_intv_cnt = intv_cnt + 8'h01;
      end
    end else begin
      next_tick_cnt = tick_cnt + 24'd1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt    <= '0;
      intv_cnt    <= '0;
      timer_pulse <= 1'b0;
    end else begin
      tick_cnt    <= next_tick_cnt;
      intv_cnt    <= next_intv_cnt;
      timer_pulse <= next_timer_pulse;
    end
  end

  // ***********************************************
  // Counting, latching and event flags
  // ***********************************************
  // Edges come from filtered lines delayed one cycle, so they stay aligned
  // with the sampling enable that moved the filter.
  always_comb begin
    logic        wr_data;
    logic        inc, dec, up;
    logic        a_r, b_r, a_c, b_c, trig;
    {inc, dec, up, a_r, b_r, a_c, b_c, trig, wr_data} = '0;
    next_flags = flags;
    if (reg_rd_in && reg_addr_in == OFS_CLK) begin
      next_flags = '0; // RULE23
    end
    for (int c = 0; c < 4; c++) begin
      inc     = 1'b0;
      dec     = 1'b0;
      up      = 1'b0;
      trig    = 1'b0;
      wr_data = 1'b0;
      a_r     = a_f[c] & ~a_p[c]; // RULE27
      b_r     = b_f[c] & ~b_p[c];
      a_c     = a_f[c] ^ a_p[c];
      b_c     = b_f[c] ^ b_p[c];
      // A leading B gives a != b on A moves and a == b on B moves.
      unique case (count_mode_t'(cmode[c]))
        CM_DISABLED: begin
          up = 1'b0; // RULE10
        end
        CM_X1: begin
          up  = ~b_f[c]; // RULE4
          inc = a_r & up; // RULE5
          dec = a_r & ~up;
        end
        CM_X2: begin
          up  = a_f[c] ^ b_f[c];
          inc = a_c & up; // RULE6
          dec = a_c & ~up;
        end
        CM_X4: begin
          up  = a_c ? (a_f[c] ^ b_f[c]) : ~(a_f[c] ^ b_f[c]);
          inc = (a_c | b_c) & up; // RULE7
          dec = (a_c | b_c) & ~up;
        end
        CM_TWO_PULSE: begin
          inc = a_r & ~b_r; // RULE8
          dec = b_r & ~a_r;
        end
        CM_PULSE_DIR: begin
          inc = a_r & ~b_f[c]; // RULE9
          dec = a_r & b_f[c];
        end
        default: begin
          up = 1'b0;
        end
      endcase
      next_count[c] = count[c] + (inc ? 32'h1 : dec ? COUNT_MAX : 32'h0); // RULE26
      if (inc && count[c] == COUNT_MAX) begin
        next_flags[INT_OV_LSB + c] = 1'b1; // RULE26 RULE19
      end
      if (dec && count[c] == 32'h0) begin
        next_flags[INT_UN_LSB + c] = 1'b1; // RULE26 RULE19
      end
      if (inc && next_count[c] == cmp[c]) begin
        next_flags[INT_OC_LSB + c] = 1'b1; // RULE19
      end
      if (dec && next_count[c] == cmp[c]) begin
        next_flags[INT_UC_LSB + c] = 1'b1; // RULE19
      end
      if (x_f[c] & ~x_p[c]) begin
        next_flags[INT_IX_LSB + c] = 1'b1; // RULE19
      end
      if (d_f[c] & ~d_p[c]) begin
        next_flags[INT_DI_LSB + c] = 1'b1; // RULE19
      end
      if (reg_wr_in && reg_addr_in == OFS_RESET && reg_wdata_in[c]) begin
        next_count[c] = rvs[c] ? RESET_VAL_ZERO : RESET_VAL_MID; // RULE25 RULE17
      end
      wr_data = reg_rd_in && reg_addr_in == 6'(OFS_MODE0 + 6'(4 * c));
      unique case (latch_src_t'(lsrc[c])) // RULE12
        LS_SOFTWARE: trig = wr_data; // RULE13
        LS_INDEX:    trig = x_f[c] & ~x_p[c]; // RULE14
        LS_DI0:      trig = d_f[0] & ~d_p[0]; // RULE15
        LS_DI1:      trig = d_f[1] & ~d_p[1]; // RULE15
        LS_DI2:      trig = d_f[2] & ~d_p[2]; // RULE15
        LS_DI3:      trig = d_f[3] & ~d_p[3]; // RULE15
        LS_TIMER:    trig = timer_pulse; // RULE16
        default:     trig = 1'b0;
      endcase
      if (reg_wr_in && reg_addr_in == OFS_LATCH && reg_wdata_in[c]) begin
        trig = 1'b1; // RULE24
      end
      next_latch[c] = trig ? count[c] : latch[c];
    end
    if (timer_pulse) begin
      next_flags[INT_TM_BIT] = 1'b1; // RULE19
    end
    next_irq = int_en[INT_IE_BIT] & |(flags & int_en & INT_SRC_MASK);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int c = 0; c < 4; c++) begin
        count[c] <= RESET_VAL_MID;
        latch[c] <= '0;
      end
      flags   <= '0;
      irq_out <= 1'b0;
      a_p     <= '0;
      b_p     <= '0;
      x_p     <= '0;
      d_p     <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        count[c] <= next_count[c];
        latch[c] <= next_latch[c];
      end
      flags   <= next_flags;
      irq_out <= next_irq;
      a_p     <= a_f;
      b_p     <= b_f;
      x_p     <= x_f;
      d_p     <= d_f;
    end
  end

  // ***********************************************
  // Register writes and reads
  // ***********************************************
  // Configuration registers load only from the host; all sit behind one decoder.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int c = 0; c < 4; c++) begin
        cmode[c] <= '0;
        lsrc[c]  <= '0;
        cmp[c]   <= '0;
      end
      rvs        <= '0;
      int_en     <= '0;
      samp_sel   <= '0;
      timer_div  <= '0;
      timer_base <= '0;
    end else if (reg_wr_in) begin
      for (int c = 0; c < 4; c++) begin
        if (reg_addr_in == 6'(OFS_MODE0 + 6'(4 * c))) begin
          cmode[c] <= reg_wdata_in[MODE_CNT_LSB +: 3]; // RULE11
          rvs[c]   <= reg_wdata_in[MODE_RVS_BIT]; // RULE17
          lsrc[c]  <= reg_wdata_in[MODE_LAT_LSB +: 3]; // RULE12
        end
        if (reg_addr_in == 6'(OFS_CMP0 + 6'(4 * c))) begin
          cmp[c] <= reg_wdata_in;
        end
      end
      if (reg_addr_in == OFS_INT) begin
        int_en <= reg_wdata_in & (INT_SRC_MASK | (32'h1 << INT_IE_BIT)); // RULE20
      end
      if (reg_addr_in == OFS_CLK) begin
        samp_sel   <= reg_wdata_in[CLK_SC_LSB +: 2]; // RULE22
        timer_div  <= reg_wdata_in[CLK_DV_LSB +: 8];
        timer_base <= reg_wdata_in[CLK_TB_LSB +: 3];
      end
    end
  end

  // Board identity is a strap, sampled on every rising clock edge, with no reset.
  always_ff @(posedge clk_in) begin
    board_id <= board_id_in;
  end

  // Read data appear the cycle after the strobe and hold until the next read.
  // In software latch mode a data read returns the live count it latched.
  always_comb begin
    next_rdata = reg_rdata_out;
    if (reg_rd_in) begin
      next_rdata = '0;
      for (int c = 0; c < 4; c++) begin
        if (reg_addr_in == 6'(OFS_MODE0 + 6'(4 * c))) begin
          next_rdata = (latch_src_t'(lsrc[c]) == LS_SOFTWARE) ? count[c] : latch[c]; // RULE12 RULE13
        end
        if (reg_addr_in == 6'(OFS_CMP0 + 6'(4 * c))) begin
          next_rdata = cmp[c];
        end
      end
      if (reg_addr_in == OFS_INT) begin
        next_rdata = flags;
        next_rdata[INT_IE_BIT] = irq_out;
      end
      if (reg_addr_in == OFS_LATCH) begin
        next_rdata = {28'h0, board_id};
      end
      if (reg_addr_in == OFS_DIO) begin
        next_rdata = {24'h0, d_f, 4'h0};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// File: qe_pkg.sv
// Constants, field layouts and mode encodings for the four-channel encoder counter.
// Functional notes
// RULE1 - Filter output follows four equal consecutive samples
// RULE2 - Sampling rate selectable 1, 2, 4, 8 MHz
// RULE3 - Software picks slowest adequate sampling rate
// RULE4 - Quadrature direction from which input leads
// RULE5 - x1 counts on rising edges of A
// RULE6 - x2 counts on both edges of A
// RULE7 - x4 counts on every A or B edge
// RULE8 - Two-pulse: A rise increments, B rise decrements
// RULE9 - Pulse/direction: A rise, B high decrements
// RULE10 - Disabled mode ignores inputs, registers stay accessible
// RULE11 - Per-channel mode registers at 00h to 0Ch
// RULE12 - Reads return latch buffer, one of seven sources
// RULE13 - Software mode latches on data register access
// RULE14 - Index rising edge latches the count
// RULE15 - Selected digital input rising edge latches count
// RULE16 - Timer pulse rising edge latches the count
// RULE17 - Reset value select: zero gives 80000000h
// RULE18 - Periodic timer pulses from 20 us to 51 s
// RULE19 - Twenty-five interrupt sources incl. timer pulse
// RULE20 - Interrupt enables live at offset 20h
// RULE21 - Software enables one source unless handler copes
// RULE22 - Sampling select 00=8, 01=4, 10=2, 11=1 MHz
// RULE23 - Reading clear register clears pending interrupt flags
// RULE24 - Software latch command copies counter to latch
// RULE25 - Counter reset command loads selected reset value
// RULE26 - 32-bit counters wrap, flag overflow and underflow
// RULE27 - Edge detection uses filtered, sample-synchronous inputs
package qe_pkg;

  // ***********************************************
  // Register offsets
  // ***********************************************
  localparam logic [5:0] OFS_MODE0 = 6'h00;
  localparam logic [5:0] OFS_CMP0  = 6'h10;
  localparam logic [5:0] OFS_INT   = 6'h20;
  localparam logic [5:0] OFS_CLK   = 6'h24;
  localparam logic [5:0] OFS_LATCH = 6'h28;
  localparam logic [5:0] OFS_RESET = 6'h2c;
  localparam logic [5:0] OFS_DIO   = 6'h30;

  // ***********************************************
  // Field layouts
  // ***********************************************
  localparam int MODE_CNT_LSB = 0;
  localparam int MODE_RVS_BIT = 4;
  localparam int MODE_LAT_LSB = 8;
  localparam int INT_OV_LSB   = 0;
  localparam int INT_UN_LSB   = 4;
  localparam int INT_IX_LSB   = 8;
  localparam int INT_DI_LSB   = 12;
  localparam int INT_OC_LSB   = 16;
  localparam int INT_UC_LSB   = 20;
  localparam int INT_TM_BIT   = 28;
  localparam int INT_IE_BIT   = 31;
  localparam logic [31:0] INT_SRC_MASK = 32'h10ff_ffff;
  localparam int CLK_SC_LSB   = 0;
  localparam int CLK_DV_LSB   = 16;
  localparam int CLK_TB_LSB   = 24;
  localparam int DIO_DI_LSB   = 4;

  // ***********************************************
  // Reset values and encodings
  // ***********************************************
  localparam logic [31:0] RESET_VAL_MID  = 32'h8000_0000;
  localparam logic [31:0] RESET_VAL_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX      = 32'hffff_ffff;
  localparam logic [2:0]  TB_LAST        = 3'h4;

  typedef enum logic [2:0] {
    CM_DISABLED, CM_X1, CM_X2, CM_X4, CM_TWO_PULSE, CM_PULSE_DIR
  } count_mode_t;

  typedef enum logic [2:0] {
    LS_SOFTWARE, LS_INDEX, LS_DI0, LS_DI1, LS_DI2, LS_DI3, LS_TIMER
  } latch_src_t;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int SYS_CLK_MHZ      = 50;
  localparam int SYS_CLK_HZ       = SYS_CLK_MHZ * 1000000;
  localparam int SAMPLE_MAX_MHZ   = 8;
  localparam int FILTER_DEPTH     = 4;
  localparam int TIMEBASE_FAST_HZ = 50000;
  localparam int TICK_CYCLES      = SYS_CLK_HZ / TIMEBASE_FAST_HZ;

endpackage

// File: qe_glitch_filter.sv
// Digital noise filter for one input line, stepped by the sampling enable.
`timescale 1ns/1ps
`default_nettype none
module qe_glitch_filter
  import qe_pkg::*;
#(
  parameter int DEPTH = FILTER_DEPTH
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic sample_en_in,
  input  wire logic raw_in,
  output logic      filt_out
);

  logic [DEPTH-1:0] hist;
  logic [DEPTH-1:0] next_hist;
  logic             next_filt;

  if (DEPTH < 2) begin : g_chk
    $error("qe_glitch_filter needs DEPTH of at least 2");
  end

  // Output moves only when every stored sample agrees, so short spikes die here.
  always_comb begin
    next_hist = hist;
    next_filt = filt_out;
    if (sample_en_in) begin
      next_hist = {hist[DEPTH-2:0], raw_in};
      if (&next_hist) begin
        next_filt = 1'b1; // RULE1
      end else if (~|next_hist) begin
        next_filt = 1'b0; // RULE1
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hist     <= '0;
      filt_out <= 1'b0;
    end else begin
      hist     <= next_hist;
      filt_out <= next_filt;
    end
  end

endmodule
`default_nettype wire

// File: qe_counter_asserts.sv
// Concurrent checks on the register port and interrupt line of the encoder counter.
`timescale 1ns/1ps
`default_nettype none
module qe_counter_checker
  import qe_pkg::*;
#(
  parameter int          CHANNELS        = 4,
  parameter int unsigned TICK_CYCLES_PAR = TICK_CYCLES
) (
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [5:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [3:0]  enc_a_in,
  input wire logic [3:0]  enc_b_in,
  input wire logic [3:0]  enc_index_in,
  input wire logic [3:0]  digital_input_in,
  input wire logic [3:0]  board_id_in,
  input wire logic        irq_out
);
  // ************************************
  // Shadow copies of written registers
  // ************************************
  logic [31:0] enables;
  logic [31:0] next_enables;
  logic [10:0] mode0;
  logic [10:0] next_mode0;
  // Mirror the enable and channel 0 mode writes; they are write-only in the block.
  always_comb begin
    next_enables = enables;
    next_mode0   = mode0;
    if (reg_wr_in && reg_addr_in == OFS_INT) next_enables = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == OFS_MODE0) next_mode0 = reg_wdata_in[10:0];
  end
  // Registered like the block itself, so both see a write on the same edge.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enables <= '0;
      mode0   <= '0;
    end else begin
      enables <= next_enables;
      mode0   <= next_mode0;
    end
  end
  // ************************************
  // Sequences and properties
  // ************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_rd(logic [5:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  // A software-source read of a disabled channel returns the live count.
  sequence s_dis_rd;
    s_rd(OFS_MODE0) ##0 mode0[2:0] == 3'h0 && mode0[10:8] == 3'h0;
  endsequence
  sequence s_reset_read;
    reg_wr_in && reg_addr_in == OFS_RESET && reg_wdata_in[0] ##1 !reg_wr_in ##1 s_dis_rd;
  endsequence
  a_clear_reads_zero: assert property (s_rd(OFS_CLK) |=> reg_rdata_out == 32'h0)
    else $error("clear register read did not return zero");
  a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 6'h30 |=> reg_rdata_out == 32'h0)
    else $error("unmapped read returned data");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  a_irq_needs_ie: assert property (irq_out |-> $past(enables[INT_IE_BIT]))
    else $error("interrupt raised with master enable off");
  a_irq_needs_src: assert property (irq_out |-> ($past(enables) & INT_SRC_MASK) != 32'h0)
    else $error("interrupt raised with no source enabled");
  a_board_id_read: assert property (s_rd(OFS_LATCH) |=>
      reg_rdata_out == {28'h0, $past(board_id_in, 2)})
    else $error("board id read mismatch");
  a_reset_value: assert property (s_reset_read |=>
      reg_rdata_out == (mode0[MODE_RVS_BIT] ? RESET_VAL_ZERO : RESET_VAL_MID))
    else $error("counter reset loaded the wrong value");
  a_disabled_frozen: assert property (s_dis_rd ##1 !reg_wr_in ##1 s_dis_rd |=>
      reg_rdata_out == $past(reg_rdata_out, 2))
    else $error("disabled channel count moved");
endmodule
bind qe_counter_top qe_counter_checker #(.CHANNELS(CHANNELS), .TICK_CYCLES_PAR(TICK_CYCLES_PAR))
  u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .enc_a_in(enc_a_in), .enc_b_in(enc_b_in),
    .enc_index_in(enc_index_in), .digital_input_in(digital_input_in),
    .board_id_in(board_id_in), .irq_out(irq_out));
`default_nettype wire

// File: qe_encoder_model.sv
// Behavioural encoder, index and digital-input source for the counter bench.
`timescale 1ns/1ps
`default_nettype none
module qe_encoder_model (
  input  wire logic       clk_in,
  output logic      [3:0] enc_a_out,
  output logic      [3:0] enc_b_out,
  output logic      [3:0] enc_index_out,
  output logic      [3:0] digital_input_out
);
  logic [1:0] phase;
  // ************************************
  // Line drivers
  // ************************************
  initial begin
    {enc_a_out, enc_b_out, enc_index_out, digital_input_out} = '0;
    phase = 2'h0;
  end
  // Gray order 00,10,11,01: only one line moves per step, and A leads B going forward.
  task automatic step(input bit fwd, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      phase = fwd ? phase + 2'h1 : phase - 2'h1;
      enc_a_out[0] = phase[1] ^ phase[0];
      enc_b_out[0] = phase[1];
      repeat (gap) @(negedge clk_in);
    end
  endtask
  // High pulse of w+1 clocks on A, B, index or one digital input, then low for w clocks.
  task automatic pulse(input int kind, input int n, input int w);
    for (int lvl = 1; lvl >= 0; lvl--) begin
      @(negedge clk_in);
      case (kind)
        0: enc_a_out[0] = 1'(lvl);
        1: enc_b_out[0] = 1'(lvl);
        2: enc_index_out[0] = 1'(lvl);
        default: digital_input_out[n] = 1'(lvl);
      endcase
      repeat (w) @(negedge clk_in);
    end
  endtask
  task automatic set_di(input logic [3:0] v);
    @(negedge clk_in);
    digital_input_out = v;
  endtask
endmodule
`default_nettype wire

// File: tb_quad_encoder_counter.sv
// Self-checking bench for the four-channel encoder counter.
`timescale 1ns/1ps
`default_nettype none
module tb_quad_encoder_counter;
  import qe_pkg::*;
  typedef struct {
    logic [31:0] v;
    logic [31:0] m;
  } note_t;
  localparam int G = 48;
  logic        clk_in;
  logic        rst_b_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic        irq_out;
  logic        rd_seen = 1'b0;
  logic [5:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic [31:0] reg_rdata_out;
  logic [31:0] seed = 32'h7040;
  logic [31:0] r;
  logic [3:0]  enc_a;
  logic [3:0]  enc_b;
  logic [3:0]  enc_ix;
  logic [3:0]  di;
  logic [3:0]  board_id_in;
  note_t       notes[$];
  note_t       n;
  int          n_fail;
  int          compares;
  int          cycles;
  int          per[4] = '{7, 13, 25, 50};
  int          delta[6] = '{1, 2, 4, 0, 1, 0};
  logic [2:0]  modes[6] = '{CM_X1, CM_X2, CM_X4, CM_TWO_PULSE, CM_PULSE_DIR, CM_DISABLED};

  qe_counter_top #(.CHANNELS(4), .TICK_CYCLES_PAR(10)) dut (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_index_in(enc_ix),
    .digital_input_in(di), .board_id_in(board_id_in), .irq_out(irq_out));
  qe_encoder_model u_enc (.clk_in(clk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
    .enc_index_out(enc_ix), .digital_input_out(di));

  // ************************************
  // Clock, timeout and helpers
  // ************************************
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // The run needs about 6600 cycles, so this ceiling only trips on a hang.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] mw(input logic [2:0] m, input logic v, input logic [2:0] s);
    return {21'h0, s, 3'h0, v, 1'b0, m};
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic exp);
    compares++;
    if (irq_out !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, irq_out, exp);
    end
  endtask
  // One strobe cycle per access, with an idle cycle before the next one.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
  endtask
  // Read data land one cycle after the strobe edge; compare with the oldest note.
  always @(posedge clk_in) rd_seen <= reg_rd_in;
  always @(negedge clk_in) begin
    if (rd_seen) begin
      n = notes.pop_front();
      chk_val(reg_rdata_out & n.m, n.v & n.m);
    end
  end
  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    {rst_b_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    r = rnd();
    board_id_in = r[3:0];
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    rd(OFS_LATCH, {28'h0, r[3:0]}, '1);
    rd(6'h34, 32'h0, '1);
    wr(OFS_CMP0, {2'b01, r[29:0]});
    wr(OFS_RESET, 32'h1);
    rd(OFS_MODE0, RESET_VAL_MID, '1);
    wr(OFS_MODE0, mw(CM_DISABLED, 1'b1, LS_SOFTWARE));
    wr(OFS_RESET, 32'h1);
    rd(OFS_MODE0, RESET_VAL_ZERO, '1);
    rd(OFS_MODE0, RESET_VAL_ZERO, '1);
    // Every counting mode sees the same forward-then-back motion.
    for (int k = 0; k < 6; k++) begin
      wr(OFS_MODE0, mw(modes[k], k[0], LS_SOFTWARE));
      wr(OFS_RESET, 32'h1);
      u_enc.step(1'b1, 8, G);
      u_enc.step(1'b0, 4, G);
      rd(OFS_MODE0, (k[0] ? 32'h0 : RESET_VAL_MID) + 32'(delta[k]), '1);
    end
    // At each sampling rate a short pulse is dropped and a long one counts.
    wr(OFS_MODE0, mw(CM_TWO_PULSE, 1'b1, LS_SOFTWARE));
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CLK, 32'(s));
      wr(OFS_RESET, 32'h1);
      u_enc.pulse(0, 0, 2 * per[s]);
      u_enc.pulse(0, 0, 6 * per[s]);
      rd(OFS_MODE0, 32'h1, '1);
    end
    wr(OFS_CLK, 32'h0);
    wr(OFS_MODE0, mw(CM_X4, 1'b1, LS_INDEX));
    wr(OFS_RESET, 32'h1);
    u_enc.step(1'b1, 3, G);
    u_enc.pulse(2, 0, G);
    u_enc.step(1'b1, 2, G);
    rd(OFS_MODE0, 32'h3, '1);
    wr(OFS_LATCH, 32'h1);
    u_enc.step(1'b1, 1, G);
    rd(OFS_MODE0, 32'h5, '1);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_MODE0, mw(CM_X4, 1'b1, 3'(2 + d)));
      u_enc.step(1'b1, 1, G);
      u_enc.pulse(3, d, G);
      u_enc.step(1'b1, 1, G);
      rd(OFS_MODE0, 32'(7 + 2 * d), '1);
    end
    wr(OFS_CLK, 32'h0001_0000);
    wr(OFS_MODE0, mw(CM_X4, 1'b1, LS_TIMER));
    u_enc.step(1'b1, 1, G);
    rd(OFS_MODE0, 32'hf, '1);
    wr(OFS_CLK, 32'h0);
    u_enc.set_di(r[7:4]);
    repeat (G) @(negedge clk_in);
    rd(OFS_DIO, {24'h0, r[7:4], 4'h0}, 32'h0000_00f0);
    u_enc.set_di(4'h0);
    // Underflow then overflow, with the interrupt masked, raised and cleared.
    wr(OFS_MODE0, mw(CM_X4, 1'b1, LS_SOFTWARE));
    wr(OFS_RESET, 32'h1);
    repeat (G) @(negedge clk_in);
    rd(OFS_CLK, 32'h0, '1);
    wr(OFS_INT, 32'h0000_0010);
    u_enc.step(1'b0, 1, G);
    chk_irq(1'b0);
    rd(OFS_MODE0, COUNT_MAX, '1);
    wr(OFS_INT, 32'h8000_0010);
    repeat (2) @(negedge clk_in);
    chk_irq(1'b1);
    u_enc.step(1'b1, 1, G);
    rd(OFS_INT, 32'h8000_0011, '1);
    rd(OFS_CLK, 32'h0, '1);
    repeat (2) @(negedge clk_in);
    chk_irq(1'b0);
    rd(OFS_INT, 32'h0, '1);
    repeat (4) @(negedge clk_in);
    stop_test();
  end
endmodule
`default_nettype wire
